// File: rtl/literal_and_table_op_decoder.sv
// literal and table instruction decoder with an Avalon-MM register slave
// Function
// - add immediate: sum to working, all five flags
// - and immediate: result to working, zero/negative
// - or immediate: result to working, zero/negative
// - xor immediate: result to working, zero/negative
// - literal minus working, all five flags
// - load immediate into working, flags untouched
// - multiply working by literal, flags untouched
// - bank load puts literal in bank low nibble
// - two-word pointer load builds 12-bit pointer value
// - return immediate: literal to working, two cycles
// - table reads, four pointer modes, two cycles
// - table writes, four pointer modes, two cycles
// - program counter change costs an extra idle cycle
// - lone second word executes as no-op
// - port read-modify-write uses pin levels
// - timer count write clears assigned prescaler
`timescale 1ns/1ps
`default_nettype none
`include "decoder_params.svh"

module literal_and_table_op_decoder
	import decoder_pkg::*;
#(
	parameter int PC_WIDTH = 21,
	parameter int TABLE_PTR_WIDTH = 21,
	parameter int TABLE_DEPTH = 256,
	parameter int TABLE_ADDR_WIDTH = 8,
	parameter int PORT_WIDTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [`BUS_ADDR_WIDTH-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// port pins
	input wire logic [PORT_WIDTH-1:0] port_pins,
	output logic [PORT_WIDTH-1:0] port_latch
);

	state_type state;
	op_type op;
	alu_result_type alu_out;
	status_flags_type status_flags;
	table_mode_type table_mode;
	logic [7:0] working;
	logic [7:0] literal;
	logic [15:0] instr;
	logic [15:0] last_instr;
	logic [3:0] bank_select_register;
	logic [11:0] indirect_pointer [`POINTER_COUNT];
	logic [15:0] product;
	logic [PC_WIDTH-1:0] program_counter;
	logic [PC_WIDTH-1:0] return_address;
	logic [TABLE_PTR_WIDTH-1:0] table_pointer;
	logic [TABLE_PTR_WIDTH-1:0] table_addr;
	logic [TABLE_PTR_WIDTH-1:0] next_table_pointer;
	logic [7:0] table_latch;
	logic [7:0] mem_read_data;
	logic pending_valid;
	logic [1:0] pending_select;
	logic [3:0] pending_upper;
	logic [PORT_WIDTH-1:0] pins_meta;
	logic [PORT_WIDTH-1:0] pins_sync;
	logic [7:0] timer_zero_count;
	logic [7:0] prescale_count;
	logic [7:0] prescale_limit;
	logic [3:0] timer_cfg;
	logic prescale_assigned;
	logic timer_tick;
	logic [31:0] merged;
	logic [31:0] read_value;
	logic take;
	logic take_write;
	logic exec_now;
	logic two_cycle;
	logic mem_write;

	// lanes whose byteenable is low keep the old register contents
	function automatic logic [31:0] merge_lanes(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] lanes);
		logic [31:0] value;
		value = old;
		for (int i = 0; i < 4; i++)
			if (lanes[i])
				value[8*i +: 8] = data[8*i +: 8];
		return value;
	endfunction : merge_lanes

	// a request is taken only while not yet answered and not in a second cycle
	assign take = (read || write) && waitrequest && (state == st_idle);
	assign take_write = take && write;
	assign exec_now = take_write && (address == `REG_INSTR);
	assign instr = writedata[15:0];
	assign literal = instr[7:0];
	assign table_mode = table_mode_type'(instr[1:0]);

	// instruction decode
	always_comb
	begin
		op = other_op;
		if (instr[15:12] == `OPC_GROUP_LITERAL)
		begin
			case (instr[11:8])
				`OPC_ADD_IMM: op = add_immediate_op;
				`OPC_AND_IMM: op = and_immediate_op;
				`OPC_OR_IMM: op = or_immediate_op;
				`OPC_XOR_IMM: op = xor_immediate_op;
				`OPC_SUB_IMM: op = subtract_from_immediate_op;
				`OPC_LOAD_IMM: op = load_immediate_op;
				`OPC_MUL_IMM: op = multiply_immediate_op;
				`OPC_RET_IMM: op = return_immediate_op;
				default:
				begin
					if (instr[11:4] == `OPC_BANK_HI)
						op = bank_load_op;
					else if (instr[11:4] == `OPC_TABLE_HI && instr[`OPC_TABLE_BIT])
						op = instr[`OPC_TABLE_WRITE_BIT] ? program_memory_write_op
							: program_memory_read_op;
				end
			endcase
		end
		else if (instr[15:8] == `OPC_PTR_FIRST && instr[7:6] == `OPC_PTR_FIRST_ZERO)
			op = pointer_load_op;
		else if (instr[15:12] == `OPC_SECOND_WORD)
			op = second_word_op;
	end

	// instructions that return or touch program memory need a second cycle
	assign two_cycle = (op == return_immediate_op) || (op == program_memory_read_op)
		|| (op == program_memory_write_op);

	literal_alu u_alu (
		.op(op),
		.working(working),
		.literal(literal),
		.flags_in(status_flags),
		.result(alu_out)
	);

	// bus handshake: one wait cycle, two for two-cycle instructions
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state <= st_idle;
			waitrequest <= 1'b1;
		end
		else
		begin
			case (state)
				st_idle:
				begin
					if (!waitrequest)
						waitrequest <= 1'b1;
					else if (exec_now && two_cycle)
						state <= st_second; // extra cycle; a table read latches its data here
					else if (take)
						waitrequest <= 1'b0;
				end
				st_second:
				begin
					state <= st_idle;
					waitrequest <= 1'b0;
				end
				default: state <= st_idle;
			endcase
		end
	end

	// read data is captured when the read is taken and held until the next read
	always_ff @(posedge clk)
	begin
		if (rst)
			readdata <= 32'h0;
		else if (take && read)
			readdata <= read_value;
	end

	assign merged = merge_lanes(read_value, writedata, byteenable);

	// working register and status flags
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			working <= `WORKING_RESET;
			status_flags <= `STATUS_RESET;
		end
		else if (exec_now)
		begin
			case (op)
				add_immediate_op, subtract_from_immediate_op, and_immediate_op,
				or_immediate_op, xor_immediate_op:
				begin
					working <= alu_out.value;
					status_flags <= alu_out.flags;
				end
				load_immediate_op, return_immediate_op:
					working <= literal; // flags untouched
				default: working <= working;
			endcase
		end
		else if (take_write && address == `REG_WORKING)
			working <= merged[7:0];
		else if (take_write && address == `REG_STATUS)
			status_flags <= status_flags_type'(merged[`STATUS_WIDTH-1:0]);
	end

	// product of the multiply, working and flags stay as they are
	always_ff @(posedge clk)
	begin
		if (rst)
			product <= 16'h0;
		else if (exec_now && op == multiply_immediate_op)
			product <= alu_out.product;
	end

	// bank select and the last instruction word
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			bank_select_register <= 4'h0;
			last_instr <= 16'h0;
		end
		else if (exec_now)
		begin
			last_instr <= instr;
			if (op == bank_load_op)
				bank_select_register <= instr[3:0];
		end
	end

	// first pointer-load word waits for its second; any other word drops it
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pending_valid <= 1'b0;
			pending_select <= 2'b00;
			pending_upper <= 4'h0;
		end
		else if (exec_now)
		begin
			pending_valid <= (op == pointer_load_op);
			pending_select <= instr[5:4];
			pending_upper <= instr[3:0];
		end
	end

	// one pointer per entry; a second word alone changes nothing
	generate
		for (genvar i = 0; i < `POINTER_COUNT; i++)
		begin : g_pointer
			always_ff @(posedge clk)
			begin
				if (rst)
					indirect_pointer[i] <= 12'h000;
				else if (exec_now && op == second_word_op && pending_valid
					&& pending_select == 2'(i))
					indirect_pointer[i] <= {pending_upper, instr[7:0]};
			end
		end
	endgenerate

	// program counter steps per word; a return reloads it
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			program_counter <= '0;
			return_address <= '0;
		end
		else if (exec_now && op == return_immediate_op)
			program_counter <= return_address;
		else if (exec_now)
			program_counter <= program_counter + PC_WIDTH'(`PC_STEP);
		else if (take_write && address == `REG_RETURN_ADDR)
			return_address <= merged[PC_WIDTH-1:0];
	end

	// table address and the pointer after the access
	always_comb
	begin
		table_addr = table_pointer;
		next_table_pointer = table_pointer;
		case (table_mode)
			tbl_no_change: next_table_pointer = table_pointer;
			tbl_post_inc: next_table_pointer = table_pointer + TABLE_PTR_WIDTH'(1);
			tbl_post_dec: next_table_pointer = table_pointer - TABLE_PTR_WIDTH'(1);
			tbl_pre_inc:
			begin
				table_addr = table_pointer + TABLE_PTR_WIDTH'(1);
				next_table_pointer = table_addr;
			end
			default: next_table_pointer = table_pointer;
		endcase
	end

	assign mem_write = exec_now && op == program_memory_write_op;

	table_memory #(
		.DEPTH(TABLE_DEPTH),
		.ADDR_WIDTH(TABLE_ADDR_WIDTH)
	) u_table (
		.clk(clk),
		.write_enable(mem_write),
		.addr(table_addr[TABLE_ADDR_WIDTH-1:0]),
		.write_data(table_latch),
		.read_data(mem_read_data)
	);

	// table pointer moves at the first cycle, read data lands in the second
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			table_pointer <= '0;
			table_latch <= 8'h00;
		end
		else if (exec_now && (op == program_memory_read_op || op == program_memory_write_op))
			table_pointer <= next_table_pointer;
		else if (state == st_second && last_instr[`OPC_TABLE_BIT]
			&& !last_instr[`OPC_TABLE_WRITE_BIT] && last_instr[15:4] == 12'h000)
			table_latch <= mem_read_data;
		else if (take_write && address == `REG_TABLE_PTR)
			table_pointer <= merged[TABLE_PTR_WIDTH-1:0];
		else if (take_write && address == `REG_TABLE_LATCH)
			table_latch <= merged[7:0];
	end

	// pins cross into the clock domain through two flops
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pins_meta <= '0;
			pins_sync <= '0;
		end
		else
		begin
			pins_meta <= port_pins;
			pins_sync <= pins_meta;
		end
	end

	// a read-modify-write XORs the data into the pin levels, so a pulled-low input writes back its data bit
	always_ff @(posedge clk)
	begin
		if (rst)
			port_latch <= '0;
		else if (take_write && address == `REG_PORT_LATCH)
			port_latch <= merged[PORT_WIDTH-1:0];
		else if (take_write && address == `REG_PORT_RMW)
			port_latch <= pins_sync ^ writedata[PORT_WIDTH-1:0];
	end

	assign prescale_assigned = timer_cfg[`TIMER_CFG_ASSIGN_BIT];
	assign prescale_limit = 8'((16'h2 << timer_cfg[`TIMER_CFG_RATIO_LSB +: 3]) - 16'h1);
	assign timer_tick = !prescale_assigned || (prescale_count == prescale_limit);

	// timer with optional prescaler; a count write restarts the prescaler
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			timer_cfg <= `TIMER_CFG_RESET;
			timer_zero_count <= 8'h00;
			prescale_count <= 8'h00;
		end
		else
		begin
			if (take_write && address == `REG_TIMER_CFG)
				timer_cfg <= merged[3:0];
			if (take_write && address == `REG_TIMER_COUNT)
			begin
				timer_zero_count <= merged[7:0];
				if (prescale_assigned)
					prescale_count <= 8'h00;
			end
			else
			begin
				if (timer_tick)
					timer_zero_count <= timer_zero_count + 8'h01;
				prescale_count <= timer_tick ? 8'h00 : prescale_count + 8'h01;
			end
		end
	end

	// register read mux, unmapped offsets read as zero
	always_comb
	begin
		read_value = 32'h0;
		case (address)
			`REG_INSTR: read_value = 32'(last_instr);
			`REG_WORKING: read_value = 32'(working);
			`REG_STATUS: read_value = 32'(status_flags);
			`REG_BANK: read_value = 32'(bank_select_register);
			`REG_PRODUCT: read_value = 32'(product);
			`REG_TABLE_PTR: read_value = 32'(table_pointer);
			`REG_TABLE_LATCH: read_value = 32'(table_latch);
			`REG_PROG_COUNTER: read_value = 32'(program_counter);
			`REG_RETURN_ADDR: read_value = 32'(return_address);
			`REG_PORT_LATCH: read_value = 32'(port_latch);
			`REG_PORT_RMW: read_value = 32'(pins_sync);
			`REG_TIMER_COUNT: read_value = 32'(timer_zero_count);
			`REG_TIMER_CFG: read_value = 32'(timer_cfg);
			default: read_value = 32'h0;
		endcase
		for (int i = 0; i < `POINTER_COUNT; i++)
			if (address == 8'(`REG_POINTER0 + `POINTER_STRIDE * i))
				read_value = 32'(indirect_pointer[i]);
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_two_cycle_answer;
		waitrequest ##1 waitrequest ##1 !waitrequest;
	endsequence

	property p_add_result;
		exec_now && op == add_immediate_op |=> working == 8'($past(working) + $past(literal))
			&& status_flags.zero == (working == 8'h00);
	endproperty
	a_add_result: assert property (p_add_result) else $error("add result wrong");

	property p_and_result;
		exec_now && op == and_immediate_op |=> working == ($past(working) & $past(literal))
			&& status_flags.carry == $past(status_flags.carry)
			&& status_flags.arithmetic_wrap_flag == $past(status_flags.arithmetic_wrap_flag);
	endproperty
	a_and_result: assert property (p_and_result) else $error("and result or flags wrong");

	property p_or_result;
		exec_now && op == or_immediate_op |=> working == ($past(working) | $past(literal))
			&& status_flags.negative == working[7];
	endproperty
	a_or_result: assert property (p_or_result) else $error("or result wrong");

	property p_xor_result;
		exec_now && op == xor_immediate_op |=> working == ($past(working) ^ $past(literal));
	endproperty
	a_xor_result: assert property (p_xor_result) else $error("xor result wrong");

	property p_sub_result;
		exec_now && op == subtract_from_immediate_op
			|=> working == 8'($past(literal) - $past(working));
	endproperty
	a_sub_result: assert property (p_sub_result) else $error("subtract result wrong");

	property p_load_keeps_flags;
		exec_now && op == load_immediate_op |=> working == $past(literal)
			&& status_flags == $past(status_flags);
	endproperty
	a_load_keeps_flags: assert property (p_load_keeps_flags) else $error("load wrong");

	property p_multiply;
		exec_now && op == multiply_immediate_op
			|=> product == 16'($past(working)) * 16'($past(literal)) && $stable(status_flags);
	endproperty
	a_multiply: assert property (p_multiply) else $error("multiply wrong");

	property p_bank_load;
		exec_now && op == bank_load_op |=> bank_select_register == $past(instr[3:0]);
	endproperty
	a_bank_load: assert property (p_bank_load) else $error("bank load wrong");

	property p_return_two_cycles;
		exec_now && op == return_immediate_op
			|-> s_two_cycle_answer ##0 program_counter == $past(return_address, 2);
	endproperty
	a_return_two_cycles: assert property (p_return_two_cycles) else $error("return timing");

	property p_table_post_inc;
		exec_now && op == program_memory_read_op && table_mode == tbl_post_inc
			|=> table_pointer == $past(table_pointer) + TABLE_PTR_WIDTH'(1);
	endproperty
	a_table_post_inc: assert property (p_table_post_inc) else $error("table pointer step");

	property p_lone_second_word;
		exec_now && op == second_word_op && !pending_valid
			|=> $stable(working) && indirect_pointer[0] == $past(indirect_pointer[0]);
	endproperty
	a_lone_second_word: assert property (p_lone_second_word) else $error("lone word acted");

	property p_prescaler_clear;
		take_write && address == `REG_TIMER_COUNT && prescale_assigned |=> prescale_count == 8'h00;
	endproperty
	a_prescaler_clear: assert property (p_prescaler_clear) else $error("prescaler kept");

endmodule : literal_and_table_op_decoder

`default_nettype wire

// File: common/decoder_params.svh
// offsets, opcode fields, bit positions and reset values of the literal/table decoder
`ifndef DECODER_PARAMS_SVH
`define DECODER_PARAMS_SVH

// register byte offsets on the bus
`define BUS_ADDR_WIDTH 8
`define REG_INSTR 8'h00
`define REG_WORKING 8'h04
`define REG_STATUS 8'h08
`define REG_BANK 8'h0c
`define REG_POINTER0 8'h10
`define REG_PRODUCT 8'h1c
`define REG_TABLE_PTR 8'h20
`define REG_TABLE_LATCH 8'h24
`define REG_PROG_COUNTER 8'h28
`define REG_RETURN_ADDR 8'h2c
`define REG_PORT_LATCH 8'h30
`define REG_PORT_RMW 8'h34
`define REG_TIMER_COUNT 8'h38
`define REG_TIMER_CFG 8'h3c
`define POINTER_COUNT 3
`define POINTER_STRIDE 4

// opcode fields
`define OPC_GROUP_LITERAL 4'h0
`define OPC_ADD_IMM 4'hf
`define OPC_AND_IMM 4'hb
`define OPC_OR_IMM 4'h9
`define OPC_XOR_IMM 4'ha
`define OPC_SUB_IMM 4'h8
`define OPC_LOAD_IMM 4'he
`define OPC_MUL_IMM 4'hd
`define OPC_RET_IMM 4'hc
`define OPC_BANK_HI 8'h10
`define OPC_TABLE_HI 8'h00
`define OPC_TABLE_BIT 3
`define OPC_TABLE_WRITE_BIT 2
`define OPC_PTR_FIRST 8'hee
`define OPC_PTR_FIRST_ZERO 2'b00
`define OPC_SECOND_WORD 4'hf

// status and timer configuration bit positions
`define STATUS_WIDTH 5
`define TIMER_CFG_ASSIGN_BIT 0
`define TIMER_CFG_RATIO_LSB 1

// reset values and steps
`define WORKING_RESET 8'h00
`define STATUS_RESET 5'h00
`define TIMER_CFG_RESET 4'h0
`define PC_STEP 2

`endif

// File: common/decoder_pkg.sv
// types shared by the literal/table decoder and its helpers
package decoder_pkg;

	typedef enum logic [3:0] {
		other_op = 4'b0000,
		add_immediate_op = 4'b0001,
		and_immediate_op = 4'b0010,
		or_immediate_op = 4'b0011,
		xor_immediate_op = 4'b0100,
		subtract_from_immediate_op = 4'b0101,
		load_immediate_op = 4'b0110,
		multiply_immediate_op = 4'b0111,
		bank_load_op = 4'b1000,
		pointer_load_op = 4'b1001,
		return_immediate_op = 4'b1010,
		program_memory_read_op = 4'b1011,
		program_memory_write_op = 4'b1100,
		second_word_op = 4'b1101
	} op_type;

	typedef enum logic [0:0] {
		st_idle = 1'b0,
		st_second = 1'b1
	} state_type;

	typedef enum logic [1:0] {
		tbl_no_change = 2'b00,
		tbl_post_inc = 2'b01,
		tbl_post_dec = 2'b10,
		tbl_pre_inc = 2'b11
	} table_mode_type;

	typedef struct packed {
		logic negative;
		logic arithmetic_wrap_flag;
		logic zero;
		logic half_byte_carry_flag;
		logic carry;
	} status_flags_type;

	typedef struct packed {
		logic [7:0] value;
		status_flags_type flags;
		logic [15:0] product;
	} alu_result_type;

endpackage : decoder_pkg

// File: rtl/literal_alu.sv
// combinational arithmetic and logic for the literal instructions
`timescale 1ns/1ps
`default_nettype none

module literal_alu
	import decoder_pkg::*;
(
	// operands
	input wire op_type op,
	input wire logic [7:0] working,
	input wire logic [7:0] literal,
	input wire status_flags_type flags_in,
	// result
	output alu_result_type result
);

	logic [8:0] wide;
	logic [4:0] low;

	// flags not named by an instruction keep their previous value
	always_comb
	begin
		result = '0;
		result.flags = flags_in;
		result.value = working;
		result.product = 16'(working) * 16'(literal);
		wide = 9'h0;
		low = 5'h0;
		case (op)
			add_immediate_op:
			begin
				wide = {1'b0, working} + {1'b0, literal};
				low = {1'b0, working[3:0]} + {1'b0, literal[3:0]};
				result.value = wide[7:0]; // wraps modulo 256
				result.flags.carry = wide[8];
				result.flags.half_byte_carry_flag = low[4];
				result.flags.arithmetic_wrap_flag = (working[7] == literal[7]) && (wide[7] != working[7]);
			end
			subtract_from_immediate_op:
			begin
				wide = {1'b0, literal} - {1'b0, working};
				low = {1'b0, literal[3:0]} - {1'b0, working[3:0]};
				result.value = wide[7:0];
				result.flags.carry = ~wide[8]; // carry set means no borrow
				result.flags.half_byte_carry_flag = ~low[4];
				result.flags.arithmetic_wrap_flag = (working[7] != literal[7]) && (wide[7] != literal[7]);
			end
			and_immediate_op: result.value = working & literal;
			or_immediate_op: result.value = working | literal;
			xor_immediate_op: result.value = working ^ literal;
			default: result.value = working;
		endcase
		result.flags.zero = (result.value == 8'h00);
		result.flags.negative = result.value[7];
	end

endmodule : literal_alu

`default_nettype wire

// File: rtl/table_memory.sv
// byte-wide program memory image reached by the table instructions
`timescale 1ns/1ps
`default_nettype none

module table_memory #(
	parameter int DEPTH = 256,
	parameter int ADDR_WIDTH = 8
) (
	// clock
	input wire logic clk,
	// access
	input wire logic write_enable,
	input wire logic [ADDR_WIDTH-1:0] addr,
	input wire logic [7:0] write_data,
	output logic [7:0] read_data
);

	logic [7:0] cells [DEPTH];

	// synchronous read, so the data is ready for the second table cycle
	always_ff @(posedge clk)
	begin
		if (write_enable)
			cells[addr] <= write_data;
		read_data <= cells[addr];
	end

endmodule : table_memory

`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the literal and table decoder
`timescale 1ns/1ps
`default_nettype none
`include "decoder_params.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end

module tb;
	// bench state
	logic clk = 0, rst = 1, read = 0, write = 0;
	logic [7:0] address = 0, port_pins = 0, port_latch, w, k;
	logic [31:0] writedata = 0, readdata, rdv, pc0;
	logic waitrequest;
	logic [8:0] r;
	logic [4:0] s, es;
	logic [3:0] opc [7];
	logic [7:0] mem [256];
	int fail_count = 0, checks_done = 0, seed = 87, lat, a, p;

	// 100 ns clock
	always #50 clk = ~clk;

	literal_and_table_op_decoder dut (.clk(clk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
		.waitrequest(waitrequest), .port_pins(port_pins), .port_latch(port_latch));

	// one avalon transfer; lat counts edges up to the answer edge, the watchdog ends a hang
	task automatic acc(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		lat = 0;
		@(posedge clk);
		address <= ad;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do
		begin
			@(posedge clk);
			lat++;
		end while (waitrequest !== 1'b0);
		rdv = readdata;
		write <= 0;
		read <= 0;
	endtask : acc

	task automatic rg(input string nm, input logic [7:0] ad, input logic [31:0] e);
		acc(0, ad, 0);
		`CHK(nm, e, rdv)
	endtask : rg

	task automatic done(input string t);
		$display("test %s done", t);
	endtask : done

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	// watchdog: far beyond the roughly 1100 cycles the tests need
	initial
	begin
		#2000000;
		fail_count++;
		finish_test();
	end

	initial
	begin
		opc = '{4'hf, 4'hb, 4'h9, 4'ha, 4'h8, 4'he, 4'hd};
		repeat (8) @(posedge clk);
		rst <= 0;
		rg("working", `REG_WORKING, 0);
		rg("status", `REG_STATUS, 0);
		`CHK("latch", 8'h00, port_latch);
		done("reset");
		// literal ops, first pass of add, and, xor and subtract hits a zero result
		for (int i = 0; i < 7; i++)
			for (int j = 0; j < 4; j++)
			begin
				w = $random(seed);
				k = $random(seed);
				s = $random(seed);
				if (j == 0) k = (i == 4 || i == 3) ? w : ((i == 1) ? ~w : -w);
				acc(1, `REG_WORKING, w);
				acc(1, `REG_STATUS, s);
				acc(0, `REG_PROG_COUNTER, 0);
				pc0 = rdv;
				acc(1, `REG_INSTR, {opc[i], k});
				`CHK("cycles", 2, lat);
				es = s;
				case (i)
					0:
					begin
						r = w + k;
						es = {r[7], w[7] == k[7] && r[7] != w[7], r[7:0] == 0, w[3:0] + k[3:0] > 15, r[8]};
					end
					1: r = w & k;
					2: r = w | k;
					3: r = w ^ k;
					4:
					begin
						r = k - w;
						es = {r[7], k[7] != w[7] && r[7] != k[7], r[7:0] == 0, k[3:0] >= w[3:0], k >= w};
					end
					5: r = k;
					default: r = w;
				endcase
				if (i > 0 && i < 4)
				begin
					es[4] = r[7];
					es[2] = r[7:0] == 0;
				end
				rg("working", `REG_WORKING, r[7:0]);
				rg("status", `REG_STATUS, es);
				if (i == 6) rg("product", `REG_PRODUCT, {8'h00, w} * k);
				rg("pc", `REG_PROG_COUNTER, pc0 + 2);
			end
		done("literal");
		k = $random(seed);
		acc(1, `REG_INSTR, {12'h010, k[3:0]});
		rg("bank", `REG_BANK, k[3:0]);
		for (int f = 0; f < 3; f++)
		begin
			w = $random(seed);
			acc(1, `REG_INSTR, {8'hee, 2'b00, 2'(f), w[3:0]});
			acc(1, `REG_INSTR, {8'hf0, k});
			rg("pointer", `REG_POINTER0 + 8'(4 * f), {w[3:0], k});
		end
		acc(0, `REG_PROG_COUNTER, 0);
		pc0 = rdv;
		acc(1, `REG_WORKING, 8'h5a);
		acc(1, `REG_INSTR, 16'hf0ab);
		rg("working", `REG_WORKING, 8'h5a);
		rg("pc", `REG_PROG_COUNTER, pc0 + 2);
		done("bank_pointer");
		acc(1, `REG_RETURN_ADDR, 32'h0001_2346);
		acc(1, `REG_INSTR, {8'h0c, k});
		`CHK("cycles", 3, lat);
		rg("working", `REG_WORKING, k);
		rg("pc", `REG_PROG_COUNTER, 32'h0001_2346);
		acc(1, `REG_STATUS, 5'h15);
		// table writes then reads, every pointer mode, pointer restarted at 0x40
		for (int rd = 0; rd < 2; rd++)
			for (int m = 0; m < 4; m++)
			begin
				k = $random(seed);
				acc(1, `REG_TABLE_PTR, 32'h40);
				if (rd == 0) acc(1, `REG_TABLE_LATCH, k);
				acc(1, `REG_INSTR, {12'h000, 1'b1, !rd[0], 2'(m)});
				`CHK("cycles", 3, lat);
				a = 64 + (m == 3);
				p = 64 + (m == 1 || m == 3) - (m == 2);
				if (rd == 0) mem[a] = k;
				rg("tbl_ptr", `REG_TABLE_PTR, p);
				if (rd == 1) rg("tbl_latch", `REG_TABLE_LATCH, mem[a]);
			end
		rg("status", `REG_STATUS, 5'h15);
		done("return_table");
		port_pins <= $random(seed);
		k = $random(seed);
		repeat (4) @(posedge clk);
		acc(1, `REG_PORT_LATCH, 8'hff);
		acc(1, `REG_PORT_RMW, k);
		@(posedge clk);
		`CHK("port", port_pins ^ k, port_latch);
		rg("pins", `REG_PORT_RMW, port_pins);
		rg("unmapped", 8'h40, 0);
		rg("misaligned", 8'h05, 0);
		done("port_map");
		// prescaler assigned at its longest ratio; a count write must restart it,
		// otherwise a tick lands before the read and the count moves on
		k = $random(seed);
		acc(1, `REG_TIMER_CFG, 4'hf);
		repeat (150) @(posedge clk);
		acc(1, `REG_TIMER_COUNT, k);
		repeat (150) @(posedge clk);
		rg("timer", `REG_TIMER_COUNT, k);
		done("timer");
		finish_test();
	end
endmodule : tb
`default_nettype wire
